// File: design/dma_channel_select_control.sv
// Register front end of a multi-channel DMA controller: base addresses,
// channel selector, banked per-channel control and graceful disable.
// Assumes a single-cycle register master and a transfer engine that
// reports per-channel busy and burst completion on the same clock.
// Functional notes
// R1: Selector holds 4-bit channel index, resets zero
// R2: Software selects channel before per-channel access
// R3: Channel control accesses hit selected channel only
// R4: Disable during transfer waits for buffer drain
// R5: Buffer empty only after current burst completes
// R6: Enable bit writes one, reads channel state
// R7: Enable bit writable while channel enabled
// R8: Soft reset restores disabled channel's registers
// R9: Soft reset ignored while channel enabled
// R10: Soft reset reads one, self-clears when done
// R11: Writing zero to soft reset does nothing
// R12: Base registers reset zero, guarded, enable-locked
// R13: Control low: enable bit1, reset bit0
// R14: Command field: none, suspend, resume
// R15: Trigger action: block, beat, transaction
// R16: Higher priority level wins arbitration
// R17: Base registers hold full readable addresses
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module dma_channel_select_control #(
  parameter int CHANNELS = 12
) (
  // Clock, reset, clock enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Transfer engine status
  input wire logic [CHANNELS-1:0] ch_busy,
  input wire logic [CHANNELS-1:0] burst_done,
  // Configuration to the engine and arbiter
  output logic [31:0] descriptor_base_address,
  output logic [31:0] writeback_base_address,
  output logic [CHANNELS-1:0] ch_enable,
  output logic [CHANNELS-1:0] ch_abort,
  output logic [CHANNELS-1:0] ch_soft_reset,
  output logic [CHANNELS*26-1:0] ch_config
);

  logic [31:0] desc_base_q;
  logic [31:0] wb_base_q;
  logic [dma_sel_pkg::SEL_W-1:0] sel_q;
  logic ctrl_en_q;
  logic guard_q;
  logic [31:0] rdata_q;
  logic [CHANNELS-1:0] en_q;
  logic [CHANNELS-1:0] stop_q;
  logic [CHANNELS-1:0] srst_q;
  logic [1:0] srst_cnt_q [CHANNELS];
  logic [25:0] hi_q [CHANNELS];
  logic [CHANNELS-1:0] abort_q;

  // Address decode
  wire hit_desc = reg_addr == dma_sel_pkg::OFF_DESC_BASE;
  wire hit_wb = reg_addr == dma_sel_pkg::OFF_WB_BASE;
  wire hit_sel = reg_addr == dma_sel_pkg::OFF_CH_SEL;
  wire hit_lo = reg_addr == dma_sel_pkg::OFF_CTRL_LO;
  wire hit_hi = reg_addr == dma_sel_pkg::OFF_CTRL_HI;
  wire hit_glb = reg_addr == dma_sel_pkg::OFF_GLOBAL;
  wire hit_sts = reg_addr == dma_sel_pkg::OFF_CH_STATUS;
  wire wr = clk_en && reg_wr;
  wire sel_valid = 32'(sel_q) < CHANNELS; // R3
  // Base registers locked by the guard or a running controller
  wire base_open = !guard_q && !ctrl_en_q; // R12
  wire ch_open = !guard_q;

  // Selected channel views
  wire [CHANNELS-1:0] sel_onehot = sel_valid ? CHANNELS'(1) << sel_q : '0; // R3
  wire sel_en = |(en_q & sel_onehot);
  wire sel_srst = |(srst_q & sel_onehot);
  wire [25:0] sel_hi = sel_valid ? hi_q[sel_q] : 26'h000_0000;
  wire [31:0] lo_view = {30'h0, sel_en, sel_srst}; // R6 R10 R13
  wire [31:0] hi_view = {6'h00, sel_hi & dma_sel_pkg::CTRL_HI_USED};

  // Field views of the selected channel and of the write data
  dma_sel_pkg::ch_cfg_s sel_cfg;
  dma_sel_pkg::ch_cfg_s wr_cfg;
  assign sel_cfg = {sel_hi[25:22], sel_hi[13:8], sel_hi[6:0]};
  assign wr_cfg = {reg_wdata[25:22], reg_wdata[13:8], reg_wdata[6:0]};

  // Read data mux, unmapped reads zero
  wire [31:0] rd_mux =
    hit_desc ? desc_base_q :
    hit_wb ? wb_base_q :
    hit_sel ? {28'h0, sel_q} :
    hit_lo ? lo_view :
    hit_hi ? hi_view :
    hit_glb ? {30'h0, guard_q, ctrl_en_q} :
    hit_sts ? {{(32-CHANNELS){1'b0}}, en_q} : 32'h0000_0000;

  // Global registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      desc_base_q <= dma_sel_pkg::BASE_RESET;
      wb_base_q <= dma_sel_pkg::BASE_RESET;
      sel_q <= '0; // R1
      ctrl_en_q <= 1'b0;
      guard_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (wr && hit_desc && base_open)
        desc_base_q <= reg_wdata; // R12 R17
      if (wr && hit_wb && base_open)
        wb_base_q <= reg_wdata; // R12 R17
      if (wr && hit_sel)
        sel_q <= reg_wdata[dma_sel_pkg::SEL_W-1:0]; // R1
      if (wr && hit_glb)
      begin
        ctrl_en_q <= reg_wdata[dma_sel_pkg::BIT_CTRL_EN];
        guard_q <= reg_wdata[dma_sel_pkg::BIT_GUARD];
      end
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Per-channel control
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++)
    begin : g_ch
      wire hit = sel_onehot[c]; // R3
      wire wr_lo = wr && hit_lo && hit && ch_open;
      wire wr_hi = wr && hit_hi && hit && ch_open;
      wire want_en = reg_wdata[dma_sel_pkg::BIT_ENABLE];
      // Soft reset only taken while disabled; zero writes ignored
      wire start_srst = wr_lo && reg_wdata[dma_sel_pkg::BIT_SOFT_RESET] && !en_q[c]; // R8 R9 R11
      wire [25:0] hi_mask = en_q[c] ? dma_sel_pkg::CTRL_HI_FREE : dma_sel_pkg::CTRL_HI_USED;
      wire srst_end = srst_q[c] && srst_cnt_q[c] == 2'(dma_sel_pkg::RESET_CYCLES - 1);

      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          en_q[c] <= 1'b0;
          stop_q[c] <= 1'b0;
          srst_q[c] <= 1'b0;
          srst_cnt_q[c] <= 2'h0;
          hi_q[c] <= dma_sel_pkg::CTRL_HI_RESET;
          abort_q[c] <= 1'b0;
        end
        else if (clk_en)
        begin
          abort_q[c] <= 1'b0;
          if (wr_lo && want_en && !srst_q[c])
          begin
            en_q[c] <= 1'b1; // R6 R7
            stop_q[c] <= 1'b0;
          end
          // Idle channel drops at once, no abort pulse, no pending stop
          else if (wr_lo && !want_en && en_q[c])
          begin
            if (ch_busy[c])
              stop_q[c] <= 1'b1; // R4
            else
            begin
              en_q[c] <= 1'b0; // R6
              stop_q[c] <= 1'b0;
            end
          end
          else if (stop_q[c] && (burst_done[c] || !ch_busy[c]))
          begin
            en_q[c] <= 1'b0; // R4 R5
            stop_q[c] <= 1'b0;
            abort_q[c] <= 1'b1;
          end
          if (wr_hi)
            hi_q[c] <= (hi_q[c] & ~hi_mask) | (reg_wdata[25:0] & hi_mask); // R14 R15 R16
          if (start_srst)
          begin
            srst_q[c] <= 1'b1; // R10
            srst_cnt_q[c] <= 2'h0;
          end
          else if (srst_end)
          begin
            srst_q[c] <= 1'b0; // R10
            hi_q[c] <= dma_sel_pkg::CTRL_HI_RESET; // R8
          end
          else if (srst_q[c])
            srst_cnt_q[c] <= srst_cnt_q[c] + 2'h1;
        end
      end

      assign ch_config[c*26 +: 26] = hi_q[c];

      a_srst_blocked: assert property (@(posedge clk) disable iff (sys_rst) // R9
        en_q[c] |=> !$rose(srst_q[c]))
        else $error("soft reset started on enabled channel");
      a_srst_clears: assert property (@(posedge clk) disable iff (sys_rst) // R10
        $rose(srst_q[c]) && clk_en ##1 clk_en |=> !srst_q[c] || !clk_en)
        else $error("soft reset did not self-clear");
      a_hold_busy: assert property (@(posedge clk) disable iff (sys_rst) // R4
        stop_q[c] && ch_busy[c] && !burst_done[c] |=> en_q[c])
        else $error("enable dropped before burst drained");
      a_abort_drop: assert property (@(posedge clk) disable iff (sys_rst) // R5
        abort_q[c] && $past(clk_en) |-> !en_q[c] && $past(en_q[c]))
        else $error("abort without enable drop");
      a_srst_restore: assert property (@(posedge clk) disable iff (sys_rst) // R8
        $fell(srst_q[c]) |-> hi_q[c] == dma_sel_pkg::CTRL_HI_RESET)
        else $error("channel config not restored");

      // Soft reset and graceful disable steps
      sequence s_srst_req;
        start_srst;
      endsequence

      sequence s_drain_done;
        clk_en && !wr_lo && stop_q[c] && (burst_done[c] || !ch_busy[c]);
      endsequence

      a_srst_start: assert property (@(posedge clk) disable iff (sys_rst) // R10
        s_srst_req |=> srst_q[c])
        else $error("soft reset did not start");
      a_srst_zero: assert property (@(posedge clk) disable iff (sys_rst) // R11
        wr_lo && !reg_wdata[dma_sel_pkg::BIT_SOFT_RESET] && !srst_q[c]
        |=> !srst_q[c])
        else $error("zero write started a soft reset");
      a_srst_refused: assert property (@(posedge clk) disable iff (sys_rst) // R9
        wr_lo && reg_wdata[dma_sel_pkg::BIT_SOFT_RESET] && en_q[c] && !srst_q[c]
        |=> !srst_q[c])
        else $error("soft reset taken on enabled channel");
      a_srst_end: assert property (@(posedge clk) disable iff (sys_rst) // R10
        clk_en && srst_end && !start_srst |=> !srst_q[c])
        else $error("soft reset outlived its count");
      a_en_take: assert property (@(posedge clk) disable iff (sys_rst) // R6
        wr_lo && want_en && !srst_q[c] |=> en_q[c])
        else $error("enable write not taken");
      a_idle_drop: assert property (@(posedge clk) disable iff (sys_rst) // R6
        wr_lo && !want_en && !ch_busy[c] |=> !en_q[c])
        else $error("idle channel stayed enabled");
      a_busy_hold: assert property (@(posedge clk) disable iff (sys_rst) // R4
        wr_lo && !want_en && en_q[c] && ch_busy[c]
        |=> en_q[c] && stop_q[c])
        else $error("busy channel dropped at once");
      a_drain_end: assert property (@(posedge clk) disable iff (sys_rst) // R5
        s_drain_done |=> !en_q[c] && abort_q[c])
        else $error("drain end did not disable channel");
      a_abort_pulse: assert property (@(posedge clk) disable iff (sys_rst) // R4
        abort_q[c] && clk_en |=> !abort_q[c])
        else $error("abort pulse longer than one cycle");
    end
  endgenerate

  // Outputs from flip-flops
  assign reg_rdata = rdata_q;
  assign descriptor_base_address = desc_base_q;
  assign writeback_base_address = wb_base_q;
  assign ch_enable = en_q;
  assign ch_abort = abort_q;
  assign ch_soft_reset = srst_q;

  sequence s_lo_read;
    clk_en && reg_rd && hit_lo;
  endsequence

  a_sel_reset: assert property (@(posedge clk) // R1
    sys_rst |=> sel_q == '0)
    else $error("selector not cleared by reset");
  a_lo_readback: assert property (@(posedge clk) disable iff (sys_rst) // R6
    s_lo_read |=> reg_rdata[dma_sel_pkg::BIT_ENABLE] == $past(sel_en))
    else $error("enable readback wrong");
  a_base_locked: assert property (@(posedge clk) disable iff (sys_rst) // R12
    ctrl_en_q && wr && hit_desc |=> $stable(desc_base_q))
    else $error("base changed while controller enabled");
  a_base_write: assert property (@(posedge clk) disable iff (sys_rst) // R17
    wr && hit_desc && base_open |=> desc_base_q == $past(reg_wdata))
    else $error("base address not stored");
  a_sel_route: assert property (@(posedge clk) disable iff (sys_rst) // R3
    wr && hit_lo && ch_open && reg_wdata[dma_sel_pkg::BIT_ENABLE] && !sel_valid
    |=> $stable(en_q))
    else $error("out-of-range selector reached a channel");

  // Base register locks and stores
  a_wb_locked: assert property (@(posedge clk) disable iff (sys_rst) // R12
    ctrl_en_q && wr && hit_wb |=> $stable(wb_base_q))
    else $error("write-back base changed while controller enabled");
  a_guard_desc: assert property (@(posedge clk) disable iff (sys_rst) // R12
    guard_q && wr && hit_desc |=> $stable(desc_base_q))
    else $error("descriptor base changed while guarded");
  a_guard_wb: assert property (@(posedge clk) disable iff (sys_rst) // R12
    guard_q && wr && hit_wb |=> $stable(wb_base_q))
    else $error("write-back base changed while guarded");
  a_wb_write: assert property (@(posedge clk) disable iff (sys_rst) // R17
    wr && hit_wb && base_open |=> wb_base_q == $past(reg_wdata))
    else $error("write-back base not stored");

  // Selector store and readback
  a_sel_write: assert property (@(posedge clk) disable iff (sys_rst) // R1
    wr && hit_sel |=> sel_q == $past(reg_wdata[dma_sel_pkg::SEL_W-1:0]))
    else $error("selector not stored");
  a_sel_read: assert property (@(posedge clk) disable iff (sys_rst) // R1
    clk_en && reg_rd && hit_sel |=> reg_rdata == {28'h000_0000, $past(sel_q)})
    else $error("selector readback wrong");

  // Control low readback
  a_srst_read: assert property (@(posedge clk) disable iff (sys_rst) // R10
    s_lo_read |=> reg_rdata[dma_sel_pkg::BIT_SOFT_RESET] == $past(sel_srst))
    else $error("soft reset readback wrong");
  a_lo_upper: assert property (@(posedge clk) disable iff (sys_rst) // R13
    s_lo_read |=> reg_rdata[31:2] == 30'h0)
    else $error("read-only control low bits not zero");

  // Channel enable vector readback
  a_status_read: assert property (@(posedge clk) disable iff (sys_rst) // R6
    clk_en && reg_rd && hit_sts
    |=> reg_rdata[CHANNELS-1:0] == $past(en_q))
    else $error("enable vector readback wrong");

  // Control high fields: free ones always, protected ones while disabled
  a_cmd_write: assert property (@(posedge clk) disable iff (sys_rst) // R14
    wr && hit_hi && ch_open && sel_valid && !sel_srst
    |=> sel_cfg.command == $past(wr_cfg.command))
    else $error("command field not stored");
  a_lvl_write: assert property (@(posedge clk) disable iff (sys_rst) // R16
    wr && hit_hi && ch_open && sel_valid && !sel_srst
    |=> sel_cfg.priority_level == $past(wr_cfg.priority_level))
    else $error("priority level not stored");
  a_trig_write: assert property (@(posedge clk) disable iff (sys_rst) // R15
    wr && hit_hi && ch_open && sel_valid && !sel_en && !sel_srst
    |=> sel_cfg.trigger_action == $past(wr_cfg.trigger_action))
    else $error("trigger action not stored");
  a_trig_locked: assert property (@(posedge clk) disable iff (sys_rst) // R15
    wr && hit_hi && sel_en && !sel_srst |=> $stable(sel_cfg.trigger_action))
    else $error("trigger action changed while enabled");
  a_src_locked: assert property (@(posedge clk) disable iff (sys_rst) // R7
    wr && hit_hi && sel_en && !sel_srst
    |=> $stable(sel_cfg.trigger_source) && $stable(sel_cfg.event_input_action))
    else $error("protected field changed while enabled");
  a_hi_read: assert property (@(posedge clk) disable iff (sys_rst) // R3
    clk_en && reg_rd && hit_hi
    |=> reg_rdata == {6'h00, $past(sel_hi & dma_sel_pkg::CTRL_HI_USED)})
    else $error("control high readback wrong");
endmodule

// File: design/dma_sel_pkg.sv
// Package for the DMA channel-select register front end.
// Assumes a 32-bit plain register port with byte offsets as printed.
package dma_sel_pkg;
  localparam logic [7:0] OFF_DESC_BASE = 8'h34;
  localparam logic [7:0] OFF_WB_BASE = 8'h38;
  localparam logic [7:0] OFF_CH_SEL = 8'h3F;
  localparam logic [7:0] OFF_CTRL_LO = 8'h40;
  localparam logic [7:0] OFF_CTRL_HI = 8'h44;
  localparam logic [7:0] OFF_GLOBAL = 8'h00;
  localparam logic [7:0] OFF_CH_STATUS = 8'h04;
  localparam int SEL_W = 4;
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_CTRL_EN = 0;
  localparam int BIT_GUARD = 1;
  localparam int CTRL_HI_W = 26;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [25:0] CTRL_HI_RESET = 26'h000_0000;
  localparam logic [25:0] CTRL_HI_USED = 26'h3C0_3F7F;
  // Fields not enable-protected: command and priority level
  localparam logic [25:0] CTRL_HI_FREE = 26'h300_0060;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_SUSPEND = 2'h1;
  localparam logic [1:0] CMD_RESUME = 2'h2;
  localparam logic [1:0] TRIG_BLOCK = 2'h0;
  localparam logic [1:0] TRIG_BEAT = 2'h2;
  localparam logic [1:0] TRIG_TRANSACTION = 2'h3;
  localparam int RESET_CYCLES = 2;
  typedef struct packed {
    logic [1:0] command;
    logic [1:0] trigger_action;
    logic [5:0] trigger_source;
    logic [1:0] priority_level;
    logic event_output_enable;
    logic event_input_enable;
    logic [2:0] event_input_action;
  } ch_cfg_s;
endpackage

// File: verification/tb.sv
// Self-checking bench for the DMA channel-select register front end.
// Assumes the single-cycle register port and the default of 12 channels.
`timescale 1ns/100ps
module tb;
  localparam int N = 12;
  logic clk, sys_rst, clk_en, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, w;
  logic [N-1:0] ch_busy, burst_done, ch_enable, ch_abort, ch_soft_reset;
  logic [N*26-1:0] ch_config;
  logic [31:0] desc_base, wb_base;
  logic [25:0] hi_exp [N];
  logic [7:0] reset_addrs [5] = '{8'h34, 8'h38, 8'h3F, 8'h40, 8'h44};
  int miscompares, cmp_count;

  dma_channel_select_control dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ch_busy(ch_busy), .burst_done(burst_done),
    .descriptor_base_address(desc_base), .writeback_base_address(wb_base),
    .ch_enable(ch_enable), .ch_abort(ch_abort), .ch_soft_reset(ch_soft_reset),
    .ch_config(ch_config));

  // Free-running 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask

  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One-cycle write strobe
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Expected control-high contents: only free fields move while enabled
  function logic [25:0] hi_next(input logic [25:0] old, input logic [31:0] d, input logic en);
    hi_next = en ? ((old & ~dma_sel_pkg::CTRL_HI_FREE) | (d[25:0] & dma_sel_pkg::CTRL_HI_FREE))
                 : (d[25:0] & dma_sel_pkg::CTRL_HI_USED);
  endfunction

  // Select a channel and write its control-high register
  task set_hi(input int ch, input logic [31:0] d, input logic en);
    wr(8'h3F, 32'(ch));
    wr(8'h44, d);
    hi_exp[ch] = hi_next(hi_exp[ch], d, en);
    rd(8'h44, v);
    check(v, {6'h00, hi_exp[ch]});
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    ch_busy = '0;
    burst_done = '0;
    void'($urandom(32'h1513CCCA));
    foreach (hi_exp[i]) hi_exp[i] = 26'h000_0000;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (reset_addrs[i])
    begin
      rd(reset_addrs[i], v);
      check(v, 32'h0000_0000);
    end
    // Base addresses, controller-enable lock, write guard, clock enable
    w = $urandom;
    wr(8'h34, w);
    wr(8'h38, ~w);
    rd(8'h34, v);
    check(v, w);
    rd(8'h38, v);
    check(v, ~w);
    check(desc_base, w);
    check(wb_base, ~w);
    wr(8'h00, 32'h0000_0001);
    wr(8'h34, 32'h0000_0000);
    rd(8'h34, v);
    check(v, w);
    wr(8'h00, 32'h0000_0002);
    wr(8'h38, 32'h0000_0000);
    rd(8'h38, v);
    check(v, ~w);
    wr(8'h00, 32'h0000_0000);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(8'h34, 32'h0000_0000);
    @(posedge clk);
    clk_en <= 1'b1;
    #1 check(desc_base, w);
    // Every code of command, trigger action and priority level
    for (int k = 0; k < 4; k++) set_hi(0, 32'((k << 24) | (k << 22) | (k << 5)), 1'b0);
    for (int ch = 0; ch < N; ch++) set_hi(ch, $urandom, 1'b0);
    for (int ch = 0; ch < N; ch++)
    begin
      wr(8'h3F, 32'(ch));
      rd(8'h3F, v);
      check(v, 32'(ch));
      rd(8'h44, v);
      check(v, {6'h00, hi_exp[ch]});
      check(ch_config[ch*26 +: 26], hi_exp[ch]);
    end
    // Selector beyond the last channel reaches nothing
    for (int s = N; s < 16; s++)
    begin
      wr(8'h3F, 32'(s));
      wr(8'h44, $urandom);
      rd(8'h44, v);
      check(v, 32'h0000_0000);
    end
    rd(8'h50, v);
    check(v, 32'h0000_0000);
    // Write guard shields channel registers but not the selector
    wr(8'h00, 32'h0000_0002);
    wr(8'h3F, 32'h0000_0005);
    wr(8'h44, ~{6'h00, hi_exp[5]});
    wr(8'h40, 32'h0000_0002);
    rd(8'h3F, v);
    check(v, 32'h0000_0005);
    rd(8'h44, v);
    check(v, {6'h00, hi_exp[5]});
    check(ch_enable[5], 1'b0);
    wr(8'h00, 32'h0000_0000);
    // Idle channel disables at once without an abort pulse
    wr(8'h40, 32'h0000_0002);
    check(ch_enable[5], 1'b1);
    wr(8'h40, 32'h0000_0000);
    check(ch_enable[5], 1'b0);
    check(ch_abort[5], 1'b0);
    // Enable, protected fields, refused soft reset
    wr(8'h3F, 32'h0000_0003);
    wr(8'h40, 32'h0000_0002);
    check(ch_enable[3], 1'b1);
    rd(8'h40, v);
    check(v, 32'h0000_0002);
    rd(8'h04, v);
    check(v, 32'h0000_0008);
    set_hi(3, $urandom, 1'b1);
    wr(8'h40, 32'h0000_0003);
    check(ch_soft_reset[3], 1'b0);
    rd(8'h40, v);
    check(v, 32'h0000_0002);
    // Graceful disable waits for the burst
    @(posedge clk);
    ch_busy[3] <= 1'b1;
    wr(8'h40, 32'h0000_0000);
    repeat (3) @(posedge clk);
    #1 check(ch_enable[3], 1'b1);
    rd(8'h40, v);
    check(v, 32'h0000_0002);
    @(posedge clk);
    burst_done[3] <= 1'b1;
    ch_busy[3] <= 1'b0;
    @(posedge clk);
    burst_done[3] <= 1'b0;
    #1 check(ch_enable[3], 1'b0);
    check(ch_abort[3], 1'b1);
    @(posedge clk);
    #1 check(ch_abort[3], 1'b0);
    // Soft reset: zero is harmless, one clears the channel and self-clears
    wr(8'h40, 32'h0000_0000);
    check(ch_soft_reset[3], 1'b0);
    check(ch_config[3*26 +: 26], hi_exp[3]);
    wr(8'h40, 32'h0000_0001);
    check(ch_soft_reset[3], 1'b1);
    rd(8'h40, v);
    check(v, 32'h0000_0001);
    @(posedge clk);
    #1 check(ch_soft_reset[3], 1'b0);
    hi_exp[3] = 26'h000_0000;
    check(ch_config[3*26 +: 26], hi_exp[3]);
    rd(8'h44, v);
    check(v, 32'h0000_0000);
    check(ch_config[2*26 +: 26], hi_exp[2]);
    tally_and_finish;
  end
endmodule
